// ==== include/tcg_pkg.sv ====
// constants and types shared by the torque cutoff safety gate
package tcg_pkg;

  // controller clock period
  localparam int unsigned CLK_PERIOD_NS = 10;
  // time the gate enable is held off while the sense line is checked
  localparam int unsigned CHECK_TIME_NS = 2000;
  localparam int unsigned CHECK_CYCLES =
    (CHECK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = $clog2(CHECK_CYCLES + 1);

  // number of power-stage switches: two three-phase bridges, high and low
  localparam int unsigned NUM_SWITCH = 12;

  // synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;

  // reset values
  localparam logic RST_FAULT = 1'b0;
  localparam logic RST_PERMIT = 1'b0;
  localparam logic RST_BUSY = 1'b1;

  // gray coded along check -> run -> blocked
  typedef enum logic [1:0] {
    ST_CHECK = 2'b00,
    ST_RUN = 2'b01,
    ST_BLOCKED = 2'b11,
    ST_SPARE = 2'b10
  } tcg_state_t;

endpackage : tcg_pkg

// ==== rtl/tcg_sync.sv ====
// two-flop level synchroniser for a group of slow inputs
`timescale 1ns/1ns
`default_nettype none
module tcg_sync
  import tcg_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } tcg_sync_st_t;

  tcg_sync_st_t s_q;
  tcg_sync_st_t s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d.meta = i_async;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sync = s_q.stable;

endmodule : tcg_sync
`default_nettype wire

// ==== rtl/tcg_gate.sv ====
// torque cutoff safety gate in front of the power-stage switch drivers
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Cutoff on: inputs three and four become safety inputs a and b.
// - Cutoff on: switches may be energized only while both safety inputs are high.
// - A self-check runs after reset and, with cutoff on, on every change to both high.
// - Outputs stay off until the self-check has passed.
// - Cutoff on: either safety input low turns every switch output off within three clock edges.
// - The gating overrides all normal control, faulty or not.
// - Cutoff is off while the jumper is fitted, on once it is removed.
// - A cutoff opens every bridge switch; phases are never shorted.
module tcg_gate
  import tcg_pkg::*;
#(
  parameter int unsigned N_SW = NUM_SWITCH
) (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_JUMPER_FITTED,
  input wire logic I_DIGITAL_INPUT_THREE,
  input wire logic I_DIGITAL_INPUT_FOUR,
  input wire logic I_GATE_SENSE,
  input wire logic [N_SW-1:0] I_SWITCH_CMD,
  output logic [N_SW-1:0] O_SWITCH_GATE,
  output logic O_GATE_ENABLE,
  output logic O_DIGITAL_INPUT_THREE,
  output logic O_DIGITAL_INPUT_FOUR,
  output logic O_TORQUE_PERMIT,
  output logic O_CHECK_BUSY,
  output logic O_FAULT
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisation

  logic [3:0] sync_out;
  logic safety_input_a;
  logic safety_input_b;
  logic jumper_fitted;
  logic gate_sense;
  logic torque_cutoff_en;

  tcg_sync #(
    .WIDTH(4)
  ) u_sync (
    .i_clk(I_CLK),
    .i_resetn(I_RESETN),
    .i_async({I_JUMPER_FITTED, I_GATE_SENSE, I_DIGITAL_INPUT_FOUR,
              I_DIGITAL_INPUT_THREE}),
    .o_sync(sync_out)
  );

  assign safety_input_a = sync_out[0];
  assign safety_input_b = sync_out[1];
  assign gate_sense = sync_out[2];
  assign jumper_fitted = sync_out[3];
  assign torque_cutoff_en = ~jumper_fitted;
  // the jumper shares the synchroniser with the pair, so a change of both
  // in one cycle is seen in one cycle; the flops reset low, which reads
  // as cutoff active and a low pair: the safe way to start

  ////////////////////////////////////////////////////////////////////////////
  // state
  //   check: driver enable held off for a fixed time, sense must read low
  //   run: commands pass while the pair stays high or the cutoff is off
  //   blocked: all off until the pair reads high or the cutoff goes off

  typedef struct packed {
    tcg_state_t st;
    logic [CNT_W-1:0] cnt;
    logic fault;
    logic permit;
    logic gate_en;
    logic busy;
    logic [N_SW-1:0] gate;
    logic din_three;
    logic din_four;
    logic safe_prev;
  } tcg_gate_st_t;

  tcg_gate_st_t s_q;
  tcg_gate_st_t s_d;

  // with the cutoff active, both high together is the only pattern that permits torque
  function automatic logic both_high(input logic a, input logic b);
    both_high = a & b;
  endfunction : both_high

  // with the cutoff active, any other pattern is a trip
  function automatic logic tripped(input logic cut_en, input logic ok);
    tripped = cut_en & ~ok;
  endfunction : tripped

  // a fresh pair: both high now after some other pattern a cycle ago
  function automatic logic rising_pair(input logic cut_en, input logic ok,
                                       input logic ok_prev);
    rising_pair = cut_en & ok & ~ok_prev;
  endfunction : rising_pair

  // the last stage in front of the drivers; nothing bypasses it
  function automatic logic [N_SW-1:0] gated(input logic pass,
                                            input logic [N_SW-1:0] cmd);
    gated = pass ? cmd : '0;
  endfunction : gated

  logic safe_ok;
  logic trip;
  logic fresh_pair;
  logic check_done;
  logic allow;

  always_comb begin
    s_d = s_q;
    safe_ok = both_high(safety_input_a, safety_input_b);
    trip = tripped(torque_cutoff_en, safe_ok);
    fresh_pair = rising_pair(torque_cutoff_en, safe_ok, s_q.safe_prev);
    check_done = (s_q.cnt == CNT_W'(CHECK_CYCLES));
    // remembered so that a both-high pattern can be told from a fresh one
    s_d.safe_prev = safe_ok;

    // the general inputs are handed back only while the cutoff is off
    s_d.din_three = torque_cutoff_en ? 1'b0 : safety_input_a;
    s_d.din_four = torque_cutoff_en ? 1'b0 : safety_input_b;

    unique case (s_q.st)
      ST_CHECK: begin
        // driver enable held off; the sense line must follow it down
        s_d.gate_en = 1'b0;
        s_d.permit = 1'b0;
        s_d.busy = 1'b1;
        if (trip) begin
          // an abort sets no fault: the pair was simply not ready
          s_d.st = ST_BLOCKED;
          s_d.cnt = '0;
        end else if (check_done) begin
          s_d.cnt = '0;
          if (gate_sense) begin
            // sense stuck high means the off path cannot be trusted
            s_d.fault = 1'b1;
            s_d.st = ST_BLOCKED;
          end else begin
            s_d.fault = 1'b0;
            s_d.st = ST_RUN;
          end
        end else begin
          s_d.cnt = s_q.cnt + CNT_W'(1);
        end
      end
      ST_RUN: begin
        s_d.busy = 1'b0;
        s_d.gate_en = 1'b0;
        s_d.permit = 1'b0;
        if (trip) begin
          s_d.st = ST_BLOCKED;
        end else if (fresh_pair) begin
          // the pair dropped and rose again while the cutoff was being
          // switched on, so this high pair has not been checked yet
          s_d.st = ST_CHECK;
          s_d.cnt = '0;
          s_d.busy = 1'b1;
        end else begin
          s_d.gate_en = 1'b1;
          s_d.permit = 1'b1;
        end
      end
      ST_BLOCKED: begin
        s_d.gate_en = 1'b0;
        s_d.permit = 1'b0;
        s_d.busy = 1'b0;
        // a fault does not wait here: a pair still high retries the check next cycle
        if (!trip) begin
          s_d.st = ST_CHECK;
          s_d.cnt = '0;
        end
      end
      default: begin
        // an illegal code falls back to a fresh check with enable, permit and switches off
        s_d.st = ST_CHECK;
        s_d.busy = 1'b1;
        s_d.cnt = '0;
        s_d.gate_en = 1'b0;
        s_d.permit = 1'b0;
      end
    endcase

    // gating sits after all control: a stuck command cannot pass
    // a cutoff opens every switch, so the windings float
    allow = (s_d.st == ST_RUN) && s_d.permit && !s_d.fault;
    s_d.gate = gated(allow, I_SWITCH_CMD);
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      // reset lands in the check state, so every power-on runs a check
      s_q <= '0;
      s_q.st <= ST_CHECK;
      s_q.fault <= RST_FAULT;
      s_q.permit <= RST_PERMIT;
      s_q.busy <= RST_BUSY;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  // the enable also drives the sense readback judged at the end of a check

  assign O_SWITCH_GATE = s_q.gate;
  assign O_GATE_ENABLE = s_q.gate_en;
  assign O_DIGITAL_INPUT_THREE = s_q.din_three;
  assign O_DIGITAL_INPUT_FOUR = s_q.din_four;
  assign O_TORQUE_PERMIT = s_q.permit;
  assign O_CHECK_BUSY = s_q.busy;
  assign O_FAULT = s_q.fault;

endmodule : tcg_gate
`default_nettype wire

// ==== dv/tcg_partner.sv ====
// far-side model: safety chain contacts and driver enable readback
`timescale 1ns/1ns
`default_nettype none
module tcg_partner (
  input wire logic i_trip_a,
  input wire logic i_trip_b,
  input wire logic i_gate_enable,
  input wire logic i_stuck,
  output logic o_safety_a,
  output logic o_safety_b,
  output logic o_sense
);
  // a closed chain drives both lines high together
  assign o_safety_a = !i_trip_a;
  assign o_safety_b = !i_trip_b;
  // a stuck readback is the only misbehaviour the bench commands
  assign o_sense = i_gate_enable | i_stuck;
endmodule : tcg_partner
`default_nettype wire

// ==== dv/tcg_gate_sva.sv ====
// assertion checker for the torque cutoff safety gate
`timescale 1ns/1ns
`default_nettype none
module tcg_gate_sva
  import tcg_pkg::*;
#(parameter int unsigned N_SW = NUM_SWITCH) (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_JUMPER_FITTED,
  input wire logic I_DIGITAL_INPUT_THREE,
  input wire logic I_DIGITAL_INPUT_FOUR,
  input wire logic [N_SW-1:0] I_SWITCH_CMD,
  input wire logic [N_SW-1:0] O_SWITCH_GATE,
  input wire logic O_GATE_ENABLE,
  input wire logic O_DIGITAL_INPUT_THREE,
  input wire logic O_DIGITAL_INPUT_FOUR,
  input wire logic O_TORQUE_PERMIT,
  input wire logic O_CHECK_BUSY,
  input wire logic O_FAULT
);
  wire logic cut = !I_JUMPER_FITTED;
  wire logic both = I_DIGITAL_INPUT_THREE && I_DIGITAL_INPUT_FOUR;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  sequence s_both_rise; cut && $rose(both); endsequence
  sequence s_passed; $past(O_CHECK_BUSY) && !O_FAULT; endsequence
  // four samples cover the two sync flops plus the output register
  property p_off;
    (cut && !both)[*4] |-> !O_GATE_ENABLE && O_SWITCH_GATE == '0;
  endproperty
  property p_float; !O_TORQUE_PERMIT |-> O_SWITCH_GATE == '0; endproperty
  property p_pass;
    O_TORQUE_PERMIT |-> O_SWITCH_GATE == $past(I_SWITCH_CMD);
  endproperty
  property p_need;
    O_TORQUE_PERMIT && $past(cut, 5) |-> $past(both, 3) || $past(both, 4);
  endproperty
  property p_busy; O_CHECK_BUSY |-> !O_GATE_ENABLE && !O_TORQUE_PERMIT;
  endproperty
  property p_run; $rose(O_TORQUE_PERMIT) |-> s_passed; endproperty
  property p_fault; O_FAULT |-> !O_TORQUE_PERMIT; endproperty
  property p_check; s_both_rise |-> ##[1:4] O_CHECK_BUSY; endproperty
  property p_remap;
    cut[*4] |-> !O_DIGITAL_INPUT_THREE && !O_DIGITAL_INPUT_FOUR;
  endproperty
  a_off: assert property (p_off) else $error("switch on, input low");
  a_float: assert property (p_float) else $error("switch on idle");
  a_pass: assert property (p_pass) else $error("command lost");
  a_need: assert property (p_need) else $error("run without both");
  a_busy: assert property (p_busy) else $error("on during check");
  a_run: assert property (p_run) else $error("run without check");
  a_fault: assert property (p_fault) else $error("run with fault");
  a_check: assert property (p_check) else $error("no check");
  a_remap: assert property (p_remap) else $error("inputs leak");
endmodule : tcg_gate_sva
`default_nettype wire

// ==== dv/tcg_gate_test.sv ====
// self-checking bench for the torque cutoff safety gate
`timescale 1ns/1ns
`default_nettype none
module tcg_gate_test;
  logic clk = 0, rstn = 0, jmp = 1, trip_a = 0, trip_b = 1, stuck = 0;
  logic [11:0] cmd = 12'h000, gate;
  logic en, d3, d4, perm, busy, flt, sense, sa, sb;
  int errors = 0, n_compared = 0, cyc = 0;
  tcg_partner tcg_partner_inst (.i_trip_a(trip_a), .i_trip_b(trip_b),
    .i_gate_enable(en), .i_stuck(stuck), .o_safety_a(sa), .o_safety_b(sb),
    .o_sense(sense));
  tcg_gate tcg_gate_inst (.I_CLK(clk), .I_RESETN(rstn), .I_JUMPER_FITTED(jmp),
    .I_DIGITAL_INPUT_THREE(sa), .I_DIGITAL_INPUT_FOUR(sb),
    .I_GATE_SENSE(sense), .I_SWITCH_CMD(cmd), .O_SWITCH_GATE(gate),
    .O_GATE_ENABLE(en), .O_DIGITAL_INPUT_THREE(d3), .O_DIGITAL_INPUT_FOUR(d4),
    .O_TORQUE_PERMIT(perm), .O_CHECK_BUSY(busy), .O_FAULT(flt));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task wrap_up();
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // the whole run needs about 1100 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      wrap_up();
    end
  end
  task t_bypass();
    idle(5);
    chk(busy, 1);
    chk(en, 0);
    idle(205);
    cmd = 12'h5a3;
    idle(2);
    chk(perm, 1);
    chk(en, 1);
    chk(gate, 12'h5a3);
    chk(d3, 1);
    chk(d4, 0);
    trip_b = 0;
    idle(3);
    chk(d4, 1);
    trip_b = 1;
    idle(3);
  endtask : t_bypass
  task t_trip();
    jmp = 0;
    idle(4);
    chk(perm, 0);
    chk(gate, 12'h000);
    chk(d3, 0);
    trip_b = 0;
    idle(4);
    chk(busy, 1);
    chk(en, 0);
    idle(205);
    chk(perm, 1);
    trip_a = 1;
    idle(4);
    chk(gate, 12'h000);
  endtask : t_trip
  task t_fault();
    stuck = 1;
    trip_a = 0;
    idle(215);
    chk(flt, 1);
    chk(perm, 0);
    stuck = 0;
    idle(420);
    chk(flt, 0);
    chk(perm, 1);
  endtask : t_fault
  initial begin
    idle(8);
    rstn = 1;
    t_bypass();
    t_trip();
    t_fault();
    wrap_up();
  end
endmodule : tcg_gate_test
bind tcg_gate tcg_gate_sva #(.N_SW(N_SW)) tcg_gate_sva_inst (.I_CLK(I_CLK),
  .I_RESETN(I_RESETN), .I_JUMPER_FITTED(I_JUMPER_FITTED),
  .I_DIGITAL_INPUT_THREE(I_DIGITAL_INPUT_THREE),
  .I_DIGITAL_INPUT_FOUR(I_DIGITAL_INPUT_FOUR), .I_SWITCH_CMD(I_SWITCH_CMD),
  .O_SWITCH_GATE(O_SWITCH_GATE), .O_GATE_ENABLE(O_GATE_ENABLE),
  .O_DIGITAL_INPUT_THREE(O_DIGITAL_INPUT_THREE),
  .O_DIGITAL_INPUT_FOUR(O_DIGITAL_INPUT_FOUR),
  .O_TORQUE_PERMIT(O_TORQUE_PERMIT), .O_CHECK_BUSY(O_CHECK_BUSY),
  .O_FAULT(O_FAULT));
`default_nettype wire
